//--- verilog/spt_pkg.sv
// Function
// - Find search starts one step above the open-circuit voltage.
// - Current limit output never exceeds the short-circuit current setting.
// - Sample once per interval while searching or tracking; 5 to 65535 ms.
// - Find mode halts at the peak, input off, peak values presented.
// - Tracking lowers voltage until power drops by tolerance, then climbs back.
// - Power tolerance programmable from zero to half nominal power.
// - Fast track jumps to the user peak point, then tracks as continuous.
// - Peak values keep updating during and after fast track.
// - Curve table of 100 setpoints stepped from start to end index.
// - Each curve point held one interval before advancing.
// - Curve sweep repeated by a count from 0 to 65535.
// - Curve end or stop switches input off, data stays readable.
// - Curve result with highest power becomes the reported peak.
// - Each completed curve run leaves readable result sets from start to end index, others cleared.
// - Peak voltage, current and power readable as separate registers.
package spt_pkg;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] SPT_REG_CTRL = 8'h00;
	localparam logic [7:0] SPT_REG_STATUS = 8'h04;
	localparam logic [7:0] SPT_REG_OC_VOLT = 8'h08;
	localparam logic [7:0] SPT_REG_SC_CURR = 8'h0C;
	localparam logic [7:0] SPT_REG_INTERVAL = 8'h10;
	localparam logic [7:0] SPT_REG_TOL_PWR = 8'h14;
	localparam logic [7:0] SPT_REG_USER_VOLT = 8'h18;
	localparam logic [7:0] SPT_REG_USER_PWR = 8'h1C;
	localparam logic [7:0] SPT_REG_START_IDX = 8'h20;
	localparam logic [7:0] SPT_REG_END_IDX = 8'h24;
	localparam logic [7:0] SPT_REG_REPS = 8'h28;
	localparam logic [7:0] SPT_REG_STEP = 8'h2C;
	localparam logic [7:0] SPT_REG_PEAK_VOLT = 8'h30;
	localparam logic [7:0] SPT_REG_PEAK_CURR = 8'h34;
	localparam logic [7:0] SPT_REG_PEAK_PWR = 8'h38;
	localparam logic [7:0] SPT_REG_TBL_IDX = 8'h3C;
	localparam logic [7:0] SPT_REG_CURVE_VOLT = 8'h40;
	localparam logic [7:0] SPT_REG_RES_VOLT = 8'h44;
	localparam logic [7:0] SPT_REG_RES_CURR = 8'h48;
	localparam logic [7:0] SPT_REG_RES_PWR = 8'h4C;
	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam int SPT_CTRL_MODE_LO = 0;
	localparam int SPT_CTRL_START_BIT = 2;
	localparam int SPT_CTRL_STOP_BIT = 3;
	localparam int SPT_IDX_W = 7;
	localparam int SPT_TBL_DEPTH = 100;
	localparam logic [SPT_IDX_W-1:0] SPT_IDX_FIRST = 7'h01;
	localparam logic [SPT_IDX_W-1:0] SPT_IDX_LAST = 7'h64;
	localparam logic [15:0] SPT_INTERVAL_MIN_MS = 16'h0005;
	localparam logic [15:0] SPT_STEP_RST = 16'h0001;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int SPT_MS_NS = 1000000;
	localparam int SPT_CLK_PERIOD_NS = 4;
	localparam int SPT_CYC_PER_MS = SPT_MS_NS / SPT_CLK_PERIOD_NS;
	// ------------------------------------------------------------
	// Modes and states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SPT_FIND_PEAK_MODE = 2'h0,
		SPT_CONTINUOUS_TRACK_MODE = 2'h1,
		SPT_FAST_TRACK_MODE = 2'h2,
		SPT_USER_CURVE_MODE = 2'h3
	} spt_mode_e;
	typedef enum logic [5:0] {
		SPT_IDLE = 6'h01,
		SPT_SEARCH = 6'h02,
		SPT_DOWN = 6'h04,
		SPT_UP = 6'h08,
		SPT_CURVE = 6'h10,
		SPT_DONE = 6'h20
	} spt_state_e;
endpackage : spt_pkg

//--- verilog/spt_tracker.sv
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module spt_tracker import spt_pkg::*; #(
	parameter int DW = 16,
	parameter int CYC_PER_MS = SPT_CYC_PER_MS,
	parameter logic [31:0] NOM_PWR = 32'h0000FFFF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Measured input values
	input wire logic [DW-1:0] meas_volt,
	input wire logic [DW-1:0] meas_curr,
	// Load control
	output logic [DW-1:0] volt_setpoint,
	output logic [DW-1:0] curr_limit,
	output logic dc_input_on,
	output logic busy
);
	localparam int PW = 2 * DW;
	localparam logic [DW-1:0] VMAX = {DW{1'b1}};
	localparam logic [31:0] TOL_MAX = NOM_PWR >> 1;

	// Refused at elaboration: power product and interval counters assume these bounds
	if (DW < 8 || DW > 16 || CYC_PER_MS < 1) begin : g_bad_param
		$error("spt_tracker: unsupported parameter values");
	end

	// ------------------------------------------------------------
	// Bus handshake: one wait cycle per access
	// ------------------------------------------------------------
	logic ack_r, ack_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic wr_take;
	logic [31:0] rd_mux;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign avs_readdata = rdata_r;
	assign wr_take = avs_write & ack_r;

	always_comb begin
		ack_nxt = (avs_read | avs_write) & ~ack_r;
		rdata_nxt = rdata_r;
		if (avs_read && !ack_r) begin
			rdata_nxt = rd_mux;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h00000000;
		end else begin
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	spt_mode_e mode_r, mode_nxt;
	logic [DW-1:0] oc_volt_r, oc_volt_nxt, sc_curr_r, sc_curr_nxt;
	logic [DW-1:0] user_volt_r, user_volt_nxt, step_r, step_nxt;
	logic [15:0] interval_r, interval_nxt, reps_r, reps_nxt;
	logic [31:0] tol_r, tol_nxt, user_pwr_r, user_pwr_nxt;
	logic [SPT_IDX_W-1:0] start_r, start_nxt, end_r, end_nxt, tidx_r, tidx_nxt;
	logic start_pulse, stop_pulse;
	spt_state_e state_r;
	wire logic idle = (state_r == SPT_IDLE) || (state_r == SPT_DONE);
	assign start_pulse = wr_take && avs_address == SPT_REG_CTRL
		&& avs_writedata[SPT_CTRL_START_BIT];
	assign stop_pulse = wr_take && avs_address == SPT_REG_CTRL
		&& avs_writedata[SPT_CTRL_STOP_BIT];

	always_comb begin
		mode_nxt = mode_r;
		oc_volt_nxt = oc_volt_r;
		sc_curr_nxt = sc_curr_r;
		user_volt_nxt = user_volt_r;
		step_nxt = step_r;
		interval_nxt = interval_r;
		reps_nxt = reps_r;
		tol_nxt = tol_r;
		user_pwr_nxt = user_pwr_r;
		start_nxt = start_r;
		end_nxt = end_r;
		tidx_nxt = tidx_r;
		// Settings frozen while running so a run sees one consistent set
		if (wr_take && idle) begin
			case (avs_address)
				SPT_REG_CTRL: mode_nxt = spt_mode_e'(avs_writedata[SPT_CTRL_MODE_LO +: 2]);
				SPT_REG_OC_VOLT: oc_volt_nxt = avs_writedata[DW-1:0];
				SPT_REG_SC_CURR: sc_curr_nxt = avs_writedata[DW-1:0];
				SPT_REG_USER_VOLT: user_volt_nxt = avs_writedata[DW-1:0];
				SPT_REG_STEP: step_nxt = avs_writedata[DW-1:0];
				SPT_REG_INTERVAL: interval_nxt = (avs_writedata[15:0] < SPT_INTERVAL_MIN_MS)
					? SPT_INTERVAL_MIN_MS : avs_writedata[15:0];
				SPT_REG_REPS: reps_nxt = avs_writedata[15:0];
				SPT_REG_TOL_PWR: tol_nxt = (avs_writedata > TOL_MAX) ? TOL_MAX : avs_writedata;
				SPT_REG_USER_PWR: user_pwr_nxt = avs_writedata;
				SPT_REG_START_IDX: start_nxt = avs_writedata[SPT_IDX_W-1:0];
				SPT_REG_END_IDX: end_nxt = avs_writedata[SPT_IDX_W-1:0];
				default: ;
			endcase
		end
		if (wr_take && avs_address == SPT_REG_TBL_IDX) begin
			tidx_nxt = avs_writedata[SPT_IDX_W-1:0];
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_r <= SPT_FIND_PEAK_MODE;
			oc_volt_r <= '0;
			sc_curr_r <= '0;
			user_volt_r <= '0;
			step_r <= DW'(SPT_STEP_RST);
			interval_r <= SPT_INTERVAL_MIN_MS;
			reps_r <= 16'h0000;
			tol_r <= 32'h00000000;
			user_pwr_r <= 32'h00000000;
			start_r <= SPT_IDX_FIRST;
			end_r <= SPT_IDX_LAST;
			tidx_r <= '0;
		end else begin
			mode_r <= mode_nxt;
			oc_volt_r <= oc_volt_nxt;
			sc_curr_r <= sc_curr_nxt;
			user_volt_r <= user_volt_nxt;
			step_r <= step_nxt;
			interval_r <= interval_nxt;
			reps_r <= reps_nxt;
			tol_r <= tol_nxt;
			user_pwr_r <= user_pwr_nxt;
			start_r <= start_nxt;
			end_r <= end_nxt;
			tidx_r <= tidx_nxt;
		end
	end

	// ------------------------------------------------------------
	// Sampling timebase
	// ------------------------------------------------------------
	logic [31:0] cyc_r, cyc_nxt;
	logic [15:0] ms_r, ms_nxt;
	logic tick;
	assign tick = !idle && cyc_r == 32'(CYC_PER_MS - 1) && ms_r == interval_r - 16'h0001;

	always_comb begin
		cyc_nxt = 32'h00000000;
		ms_nxt = 16'h0000;
		if (!idle && !tick) begin
			cyc_nxt = (cyc_r == 32'(CYC_PER_MS - 1)) ? 32'h00000000 : cyc_r + 32'h00000001;
			ms_nxt = (cyc_r == 32'(CYC_PER_MS - 1)) ? ms_r + 16'h0001 : ms_r;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cyc_r <= 32'h00000000;
			ms_r <= 16'h0000;
		end else begin
			cyc_r <= cyc_nxt;
			ms_r <= ms_nxt;
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	spt_state_e state_nxt;
	logic [DW-1:0] setp_r, setp_nxt, pk_volt_r, pk_volt_nxt, pk_curr_r, pk_curr_nxt;
	logic [31:0] pk_pwr_r, pk_pwr_nxt;
	logic [SPT_IDX_W-1:0] idx_r, idx_nxt;
	logic [15:0] rep_r, rep_nxt;
	logic dc_r, dc_nxt, err_r, err_nxt, res_clr, res_we;
	logic [31:0] pwr;
	logic [DW-1:0] curve_tbl [SPT_TBL_DEPTH];
	logic [DW-1:0] res_v [SPT_TBL_DEPTH];
	logic [DW-1:0] res_i [SPT_TBL_DEPTH];
	logic [31:0] res_p [SPT_TBL_DEPTH];
	wire logic below_tol = ({1'b0, pwr} + {1'b0, tol_r}) <= {1'b0, pk_pwr_r};
	wire logic can_down = setp_r >= step_r;
	wire logic [DW-1:0] setp_up = (setp_r > VMAX - step_r) ? VMAX : setp_r + step_r;
	wire logic [DW-1:0] oc_up = (oc_volt_r > VMAX - step_r) ? VMAX : oc_volt_r + step_r;
	assign pwr = 32'(PW'(meas_volt) * PW'(meas_curr));

	always_comb begin
		state_nxt = state_r;
		setp_nxt = setp_r;
		pk_volt_nxt = pk_volt_r;
		pk_curr_nxt = pk_curr_r;
		pk_pwr_nxt = pk_pwr_r;
		idx_nxt = idx_r;
		rep_nxt = rep_r;
		dc_nxt = dc_r;
		err_nxt = err_r;
		res_clr = 1'b0;
		res_we = 1'b0;
		case (state_r)
			SPT_IDLE, SPT_DONE: begin
				if (start_pulse) begin
					err_nxt = 1'b0;
					pk_volt_nxt = '0;
					pk_curr_nxt = '0;
					pk_pwr_nxt = 32'h00000000;
					case (mode_nxt)
						SPT_USER_CURVE_MODE: begin
							if (start_r > end_r || start_r < SPT_IDX_FIRST || end_r > SPT_IDX_LAST) begin
								err_nxt = 1'b1;
								dc_nxt = 1'b0;
								state_nxt = SPT_IDLE;
							end else begin
								res_clr = 1'b1;
								idx_nxt = start_r - SPT_IDX_FIRST;
								setp_nxt = curve_tbl[start_r - SPT_IDX_FIRST];
								rep_nxt = 16'h0000;
								dc_nxt = 1'b1;
								state_nxt = SPT_CURVE;
							end
						end
						SPT_FAST_TRACK_MODE: begin
							// Jump to the user peak point
							setp_nxt = user_volt_r;
							pk_volt_nxt = user_volt_r;
							pk_pwr_nxt = user_pwr_r;
							dc_nxt = 1'b1;
							state_nxt = SPT_DOWN;
						end
						default: begin
							setp_nxt = oc_up;
							dc_nxt = 1'b1;
							state_nxt = SPT_SEARCH;
						end
					endcase
				end
			end
			SPT_SEARCH: begin
				if (tick) begin
					if (pwr >= pk_pwr_r && can_down) begin
						pk_volt_nxt = meas_volt;
						pk_curr_nxt = meas_curr;
						pk_pwr_nxt = pwr;
						setp_nxt = setp_r - step_r;
					end else if (mode_r == SPT_FIND_PEAK_MODE) begin
						dc_nxt = 1'b0;
						state_nxt = SPT_DONE;
					end else begin
						state_nxt = SPT_DOWN;
					end
				end
			end
			SPT_DOWN: begin
				if (tick) begin
					if (pwr > pk_pwr_r) begin
						pk_volt_nxt = meas_volt;
						pk_curr_nxt = meas_curr;
						pk_pwr_nxt = pwr;
					end
					if (below_tol || !can_down) begin
						setp_nxt = setp_up;
						state_nxt = SPT_UP;
					end else begin
						setp_nxt = setp_r - step_r;
					end
				end
			end
			SPT_UP: begin
				if (tick) begin
					// Back at the peak, descend again
					if (pwr >= pk_pwr_r) begin
						pk_volt_nxt = meas_volt;
						pk_curr_nxt = meas_curr;
						pk_pwr_nxt = pwr;
						setp_nxt = can_down ? setp_r - step_r : setp_r;
						state_nxt = SPT_DOWN;
					end else begin
						setp_nxt = setp_up;
					end
				end
			end
			SPT_CURVE: begin
				if (tick) begin
					res_we = 1'b1;
					if (pwr > pk_pwr_r) begin
						pk_volt_nxt = meas_volt;
						pk_curr_nxt = meas_curr;
						pk_pwr_nxt = pwr;
					end
					if (idx_r == end_r - SPT_IDX_FIRST) begin
						if (rep_r == reps_r) begin
							dc_nxt = 1'b0;
							state_nxt = SPT_DONE;
						end else begin
							rep_nxt = rep_r + 16'h0001;
							idx_nxt = start_r - SPT_IDX_FIRST;
							setp_nxt = curve_tbl[start_r - SPT_IDX_FIRST];
						end
					end else begin
						idx_nxt = idx_r + 7'h01;
						setp_nxt = curve_tbl[idx_r + 7'h01];
					end
				end
			end
			default: begin
				dc_nxt = 1'b0;
				state_nxt = SPT_IDLE;
			end
		endcase
		if (stop_pulse && !idle) begin
			dc_nxt = 1'b0;
			state_nxt = SPT_DONE;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= SPT_IDLE;
			setp_r <= '0;
			pk_volt_r <= '0;
			pk_curr_r <= '0;
			pk_pwr_r <= 32'h00000000;
			idx_r <= '0;
			rep_r <= 16'h0000;
			dc_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			setp_r <= setp_nxt;
			pk_volt_r <= pk_volt_nxt;
			pk_curr_r <= pk_curr_nxt;
			pk_pwr_r <= pk_pwr_nxt;
			idx_r <= idx_nxt;
			rep_r <= rep_nxt;
			dc_r <= dc_nxt;
			err_r <= err_nxt;
		end
	end

	assign volt_setpoint = setp_r;
	// Drawn current capped at short-circuit setting
	assign curr_limit = sc_curr_r;
	assign dc_input_on = dc_r;
	assign busy = !idle;

	// ------------------------------------------------------------
	// Curve table and result sets
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < SPT_TBL_DEPTH; g++) begin : g_ent
			logic [DW-1:0] cv_nxt, rv_nxt, ri_nxt;
			logic [31:0] rp_nxt;
			always_comb begin
				cv_nxt = curve_tbl[g];
				rv_nxt = res_v[g];
				ri_nxt = res_i[g];
				rp_nxt = res_p[g];
				if (wr_take && idle && avs_address == SPT_REG_CURVE_VOLT && tidx_r == SPT_IDX_W'(g)) begin
					cv_nxt = avs_writedata[DW-1:0];
				end
				if (res_clr) begin
					rv_nxt = '0;
					ri_nxt = '0;
					rp_nxt = 32'h00000000;
				end else if (res_we && idx_r == SPT_IDX_W'(g)) begin
					rv_nxt = meas_volt;
					ri_nxt = meas_curr;
					rp_nxt = pwr;
				end
			end
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					curve_tbl[g] <= '0;
					res_v[g] <= '0;
					res_i[g] <= '0;
					res_p[g] <= 32'h00000000;
				end else begin
					curve_tbl[g] <= cv_nxt;
					res_v[g] <= rv_nxt;
					res_i[g] <= ri_nxt;
					res_p[g] <= rp_nxt;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	wire logic tidx_ok = tidx_r < SPT_IDX_W'(SPT_TBL_DEPTH);
	always_comb begin
		rd_mux = 32'h00000000;
		case (avs_address)
			SPT_REG_CTRL: rd_mux = 32'(mode_r);
			SPT_REG_STATUS: rd_mux = {24'h000000, err_r, dc_r, state_r};
			SPT_REG_OC_VOLT: rd_mux = 32'(oc_volt_r);
			SPT_REG_SC_CURR: rd_mux = 32'(sc_curr_r);
			SPT_REG_INTERVAL: rd_mux = 32'(interval_r);
			SPT_REG_TOL_PWR: rd_mux = tol_r;
			SPT_REG_USER_VOLT: rd_mux = 32'(user_volt_r);
			SPT_REG_USER_PWR: rd_mux = user_pwr_r;
			SPT_REG_START_IDX: rd_mux = 32'(start_r);
			SPT_REG_END_IDX: rd_mux = 32'(end_r);
			SPT_REG_REPS: rd_mux = 32'(reps_r);
			SPT_REG_STEP: rd_mux = 32'(step_r);
			SPT_REG_PEAK_VOLT: rd_mux = 32'(pk_volt_r);
			SPT_REG_PEAK_CURR: rd_mux = 32'(pk_curr_r);
			SPT_REG_PEAK_PWR: rd_mux = pk_pwr_r;
			SPT_REG_TBL_IDX: rd_mux = 32'(tidx_r);
			SPT_REG_CURVE_VOLT: rd_mux = tidx_ok ? 32'(curve_tbl[tidx_r]) : 32'h00000000;
			SPT_REG_RES_VOLT: rd_mux = tidx_ok ? 32'(res_v[tidx_r]) : 32'h00000000;
			SPT_REG_RES_CURR: rd_mux = tidx_ok ? 32'(res_i[tidx_r]) : 32'h00000000;
			SPT_REG_RES_PWR: rd_mux = tidx_ok ? res_p[tidx_r] : 32'h00000000;
			default: rd_mux = 32'h00000000;
		endcase
	end
endmodule : spt_tracker

//--- verification/spt_tracker_props.sv
`timescale 1ns/1ps
module spt_tracker_props #(
	parameter int DW = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Load side
	input wire logic [DW-1:0] meas_volt,
	input wire logic [DW-1:0] meas_curr,
	input wire logic [DW-1:0] volt_setpoint,
	input wire logic [DW-1:0] curr_limit,
	input wire logic dc_input_on,
	input wire logic busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	logic rd_ok;
	logic unmapped;
	assign rd_ok = avs_read && !avs_waitrequest;
	assign unmapped = (avs_address[1:0] != 2'h0) || (avs_address > 8'h4C);
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	a_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait without request");
	a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without read");
	a_hole_zero: assert property (rd_ok && unmapped |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (rd_ok && avs_address inside {8'h08, 8'h0C, 8'h10, 8'h20,
		8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h40, 8'h44, 8'h48}
		|-> avs_readdata[31:16] == 16'h0)
		else $error("narrow register upper bits set");
	a_dc_busy: assert property (dc_input_on |-> busy)
		else $error("input on outside a run");
	a_start_on: assert property ($rose(busy) |-> dc_input_on)
		else $error("run started with input off");
	a_limit_hold: assert property (busy && $past(busy) |-> $stable(curr_limit))
		else $error("current limit moved in run");
	a_step_hold: assert property (busy && $past(busy) && $changed(volt_setpoint)
		|=> ($stable(volt_setpoint) || !busy) [*8])
		else $error("setpoint stepped twice in an interval");
endmodule : spt_tracker_props

//--- verification/spt_panel.sv
`timescale 1ns/1ps
module spt_panel (
	// Clock
	input wire logic clk,
	// Load side
	input wire logic [15:0] volt_setpoint,
	input wire logic dc_input_on,
	output logic [15:0] meas_volt,
	output logic [15:0] meas_curr
);
	localparam logic [15:0] VOC = 16'h0028;
	// Flat current up to the knee, then falling to zero at open circuit
	function automatic logic [15:0] cur_of(input logic [15:0] v);
		return (v >= VOC) ? 16'h0000 : (v <= 16'h0014) ? 16'h0014 : VOC - v;
	endfunction : cur_of
	initial begin
		meas_volt = VOC;
		meas_curr = 16'h0000;
	end
	// Open input shows the unloaded voltage
	always @(posedge clk) begin
		meas_volt <= dc_input_on ? volt_setpoint : VOC;
		meas_curr <= dc_input_on ? cur_of(volt_setpoint) : 16'h0000;
	end
endmodule : spt_panel

//--- verification/test_solar_peak_power_tracker.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module test_solar_peak_power_tracker import spt_pkg::*;;
	logic clk;
	logic nrst;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [15:0] meas_volt;
	logic [15:0] meas_curr;
	logic [15:0] volt_setpoint;
	logic [15:0] curr_limit;
	logic dc_input_on;
	logic busy;
	int bad_count;
	int n_checks;
	spt_tracker #(.CYC_PER_MS(4), .NOM_PWR(32'h00000100)) u_spt_tracker (.clk(clk), .nrst(nrst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .meas_volt(meas_volt), .meas_curr(meas_curr),
		.volt_setpoint(volt_setpoint), .curr_limit(curr_limit), .dc_input_on(dc_input_on),
		.busy(busy));
	spt_panel u_spt_panel (.clk(clk), .volt_setpoint(volt_setpoint), .dc_input_on(dc_input_on),
		.meas_volt(meas_volt), .meas_curr(meas_curr));
	// ------------------------------------------------------------
	// Bus and helper tasks
	// ------------------------------------------------------------
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		`CHK($sformatf("reg_%h", a), e, r)
	endtask : rchk
	task automatic wait_idle(output int n);
		n = 0;
		@(posedge clk);
		while (busy !== 1'b0 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		`CHK("busy", 1'b0, busy)
	endtask : wait_idle
	task automatic stop_run();
		wr(SPT_REG_CTRL, 32'h8);
		@(posedge clk);
		`CHK("dc_on", 1'b0, dc_input_on)
	endtask : stop_run
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// interval floor and resets
	task automatic t_regs();
		rchk(SPT_REG_STATUS, 32'h1);
		rchk(SPT_REG_START_IDX, 32'h1);
		rchk(SPT_REG_END_IDX, 32'h64);
		rchk(SPT_REG_STEP, 32'h1);
		rchk(8'hFC, 32'h0);
		wr(SPT_REG_INTERVAL, 32'h2);
		rchk(SPT_REG_INTERVAL, 32'h5);
	endtask : t_regs
	task automatic t_find();
		int n;
		wr(SPT_REG_OC_VOLT, 32'h28);
		wr(SPT_REG_SC_CURR, 32'h30);
		wr(SPT_REG_CTRL, 32'h4);
		@(posedge clk);
		`CHK("setpoint", 16'h0029, volt_setpoint)
		`CHK("curr_limit", 16'h0030, curr_limit)
		wait_idle(n);
		`CHK("dc_on", 1'b0, dc_input_on)
		rchk(SPT_REG_PEAK_VOLT, 32'h14);
		rchk(SPT_REG_PEAK_CURR, 32'h14);
		rchk(SPT_REG_PEAK_PWR, 32'h190);
	endtask : t_find
	task automatic t_track(input logic [31:0] tol, input logic [15:0] lo);
		logic [15:0] mn;
		logic [15:0] mx;
		mn = 16'hFFFF;
		mx = 16'h0000;
		wr(SPT_REG_TOL_PWR, tol);
		wr(SPT_REG_CTRL, 32'h5);
		repeat (1500) @(posedge clk);
		repeat (600) begin
			@(posedge clk);
			if (volt_setpoint < mn) mn = volt_setpoint;
			if (volt_setpoint > mx) mx = volt_setpoint;
		end
		`CHK("low_turn", lo, mn)
		`CHK("high_turn", 16'h0014, mx)
		`CHK("dc_on", 1'b1, dc_input_on)
		stop_run();
	endtask : t_track
	task automatic t_fast();
		wr(SPT_REG_USER_VOLT, 32'h19);
		wr(SPT_REG_USER_PWR, 32'h177);
		wr(SPT_REG_CTRL, 32'h6);
		@(posedge clk);
		`CHK("setpoint", 16'h0019, volt_setpoint)
		rchk(SPT_REG_PEAK_VOLT, 32'h19);
		rchk(SPT_REG_PEAK_PWR, 32'h177);
		repeat (1000) @(posedge clk);
		// Panel peak sits at 20 V, 20 A, 400 W
		rchk(SPT_REG_PEAK_VOLT, 32'h14);
		stop_run();
		rchk(SPT_REG_PEAK_CURR, 32'h14);
		rchk(SPT_REG_PEAK_PWR, 32'h190);
	endtask : t_fast
	task automatic t_curve();
		int n;
		int k;
		logic [15:0] v;
		logic [15:0] c;
		for (k = 0; k < 5; k++) begin
			wr(SPT_REG_TBL_IDX, k);
			wr(SPT_REG_CURVE_VOLT, 32'hA + 5 * k);
		end
		wr(SPT_REG_START_IDX, 32'h2);
		wr(SPT_REG_END_IDX, 32'h4);
		wr(SPT_REG_REPS, 32'h1);
		wr(SPT_REG_CTRL, 32'h7);
		wait_idle(n);
		`CHK("run_len", 1'b1, n >= 115 && n <= 125)
		`CHK("dc_on", 1'b0, dc_input_on)
		for (k = 0; k < 5; k++) begin
			v = (k >= 1 && k <= 3) ? 16'(10 + 5 * k) : 16'h0000;
			c = (k == 3) ? 16'h000F : (k >= 1 && k <= 2) ? 16'h0014 : 16'h0000;
			wr(SPT_REG_TBL_IDX, k);
			rchk(SPT_REG_RES_VOLT, {16'h0, v});
			rchk(SPT_REG_RES_CURR, {16'h0, c});
			rchk(SPT_REG_RES_PWR, v * c);
		end
		wr(SPT_REG_TBL_IDX, 32'h63);
		rchk(SPT_REG_RES_PWR, 32'h0);
		rchk(SPT_REG_PEAK_VOLT, 32'h14);
		rchk(SPT_REG_PEAK_CURR, 32'h14);
		rchk(SPT_REG_PEAK_PWR, 32'h190);
	endtask : t_curve
	task automatic t_refuse();
		logic [31:0] s;
		wr(SPT_REG_START_IDX, 32'h5);
		wr(SPT_REG_END_IDX, 32'h3);
		wr(SPT_REG_CTRL, 32'h7);
		@(posedge clk);
		`CHK("busy", 1'b0, busy)
		`CHK("dc_on", 1'b0, dc_input_on)
		bus(1'b0, SPT_REG_STATUS, 32'h0, s);
		`CHK("status_err", 2'b10, s[7:6])
	endtask : t_refuse
	task automatic t_reset();
		wr(SPT_REG_CTRL, 32'h4);
		repeat (50) @(posedge clk);
		`CHK("busy_run", 1'b1, busy)
		nrst <= 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		`CHK("dc_rst", 1'b0, dc_input_on)
		`CHK("setp_rst", 16'h0000, volt_setpoint)
		rchk(SPT_REG_STATUS, 32'h1);
		rchk(SPT_REG_OC_VOLT, 32'h0);
	endtask : t_reset
	// ------------------------------------------------------------
	// Clock, reset, sequence, watchdog
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		nrst = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		bad_count = 0;
		n_checks = 0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_find();
		t_track(32'h28, 16'h12);
		t_track(32'hFFFF, 16'hD);
		t_fast();
		t_curve();
		t_refuse();
		t_reset();
		summarize();
	end
	// Whole run is near 6000 cycles
	initial begin
		repeat (30000) @(posedge clk);
		bad_count++;
		summarize();
	end
endmodule : test_solar_peak_power_tracker
bind spt_tracker spt_tracker_props #(.DW(DW)) u_spt_tracker_props (.clk(clk), .nrst(nrst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .meas_volt(meas_volt), .meas_curr(meas_curr),
	.volt_setpoint(volt_setpoint), .curr_limit(curr_limit), .dc_input_on(dc_input_on),
	.busy(busy));
